// >>> inc/fee_pkg.sv
// package for the frequency error estimator: register map, fields, codes
`default_nettype none
package fee_pkg;
  // register indices; each register is one 32-bit word, so the byte address is four times the index
  localparam logic [7:0] FEE_IDX_RESULT   = 8'h16;  // freq_offset_result, read only
  localparam logic [7:0] FEE_IDX_CONTROL  = 8'h15;  // freq_error_control
  // register map (byte addresses)
  localparam logic [7:0] FEE_ADDR_RESULT  = {FEE_IDX_RESULT[5:0], 2'b00};
  localparam logic [7:0] FEE_ADDR_CONTROL = {FEE_IDX_CONTROL[5:0], 2'b00};
  // control field layout
  localparam int FEE_CTL_W      = 4;
  localparam int FEE_MODE_LSB   = 0;
  localparam int FEE_WIN_LSB    = 2;
  localparam logic [3:0] FEE_CTL_RESET = 4'h0;
  // mode codes of the two low control bits
  localparam logic [1:0] FEE_MODE_OFF = 2'b00;
  localparam logic [1:0] FEE_MODE_RUN = 2'b11;
  // window lengths in bit periods per select code
  localparam logic [7:0] FEE_WIN_0 = 8'h08;
  localparam logic [7:0] FEE_WIN_1 = 8'h10;
  localparam logic [7:0] FEE_WIN_2 = 8'h20;
  localparam logic [7:0] FEE_WIN_3 = 8'h40;
  localparam logic [7:0] FEE_RESULT_RESET = 8'h00;
  // axi answers
  localparam logic [1:0] FEE_RESP_OKAY   = 2'b00;
  localparam logic [1:0] FEE_RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// >>> hdl/fee_tally.sv
// signed wrapping up/down tally of demodulator pulses
`timescale 1ns/1ps
`default_nettype none
module fee_tally #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         nrst,
  // control
  input  wire logic         clear,
  input  wire logic         raise_pulse,
  input  wire logic         lower_pulse,
  // running count
  output logic [W-1:0]      count
);
  logic [W-1:0] count_reg;
  assign count = count_reg;

  // wraps modulo 2^W; simultaneous raise and lower cancel
  always_ff @(posedge clock) begin
    if (!nrst || clear) begin
      count_reg <= '0;
    end else if (raise_pulse && !lower_pulse) begin
      count_reg <= count_reg + W'(1);   // see R4 see R9
    end else if (lower_pulse && !raise_pulse) begin
      count_reg <= count_reg - W'(1);   // see R4
    end
  end
endmodule
`default_nettype wire

// >>> hdl/fee_top.sv
// frequency error estimator with axi4-lite register access
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1 - runs on code 11, off on 00
// R2 - software never writes codes 01 or 10
// R3 - period counter triggers at selected window
// R4 - tally adds raise pulses, subtracts lower
// R5 - demodulator delivers pulses per received bit
// R6 - trigger copies tally to result, clears
// R7 - result at 0x16, 8-bit two's complement
// R8 - read returns last captured value
// R9 - tally wraps, never saturates
// R10 - software converts result to frequency offset
// R11 - transmitter sends balanced pattern
// R12 - software prefers 8 or 16 windows
// R13 - trim uses sign only, zero negative
// R14 - trim search, 5-bit, start 16
// R15 - positive result lowers trim value
// R16 - wait one window before reading
// R17 - result register read-only, eight bits
// R18 - off state holds both counters cleared
module fee_top
  import fee_pkg::*;
#(
  parameter int TALLY_W = 8
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         nrst,
  // demodulator side
  input  wire logic         bit_period,
  input  wire logic         raise_pulse,
  input  wire logic         lower_pulse,
  // axi4-lite write address
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [7:0]   s_axi_awaddr,
  // axi4-lite write data
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  // axi4-lite write response
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  output logic [1:0]        s_axi_bresp,
  // axi4-lite read address
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  input  wire logic [7:0]   s_axi_araddr,
  // axi4-lite read data
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  // status
  output logic              window_trigger
);
  import fee_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [FEE_CTL_W-1:0] ctl_reg;
  logic [TALLY_W-1:0]   result_reg;
  logic [7:0]           period_reg;
  logic [7:0]           window_len;
  logic [TALLY_W-1:0]   tally;
  logic                 running;
  logic                 trigger;
  logic                 aw_held_reg;
  logic                 w_held_reg;
  logic [7:0]           awaddr_reg;
  logic [31:0]          wdata_reg;
  logic                 wstrb0_reg;
  logic                 do_write;

  // only the full enable code runs; the unused codes behave as off
  assign running = (ctl_reg[FEE_MODE_LSB +: 2] == FEE_MODE_RUN);  // see R1 see R2

  // window length select from the upper control bits
  always_comb begin
    case (ctl_reg[FEE_WIN_LSB +: 2])
      2'b00:   window_len = FEE_WIN_0;  // see R3
      2'b01:   window_len = FEE_WIN_1;
      2'b10:   window_len = FEE_WIN_2;
      2'b11:   window_len = FEE_WIN_3;
      default: window_len = FEE_WIN_0;
    endcase
  end

  // trigger on the bit period that completes the window
  assign trigger        = running && bit_period && (period_reg == window_len - 8'h01);  // see R3
  assign window_trigger = trigger;

  // ------------------------------------------------------------
  // period counter
  // ------------------------------------------------------------
  // held cleared while off so enabling starts a full window
  always_ff @(posedge clock) begin
    if (!nrst || !running) begin
      period_reg <= 8'h00;                // see R18
    end else if (trigger) begin
      period_reg <= 8'h00;                // see R3
    end else if (bit_period) begin
      period_reg <= period_reg + 8'h01;
    end
  end

  // tally of raise and lower pulses; cleared by trigger or when off
  fee_tally #(
    .W (TALLY_W)
  ) u_tally (
    .clock       (clock),
    .nrst        (nrst),
    .clear       (trigger || !running),   // see R6 see R18
    .raise_pulse (raise_pulse && running), // see R5
    .lower_pulse (lower_pulse && running),
    .count       (tally)
  );

  // result captures the tally at each trigger only
  always_ff @(posedge clock) begin
    if (!nrst) begin
      result_reg <= FEE_RESULT_RESET;
    end else if (trigger) begin
      result_reg <= tally;                // see R6 see R8
    end
  end

  // ------------------------------------------------------------
  // axi4-lite write path
  // ------------------------------------------------------------
  // address and data are accepted independently, one write at a time
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign do_write      = aw_held_reg && w_held_reg;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb0_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb0_reg <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  // control register; the result register ignores writes
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctl_reg <= FEE_CTL_RESET;
    end else if (do_write && wstrb0_reg && awaddr_reg == FEE_ADDR_CONTROL) begin
      ctl_reg <= wdata_reg[FEE_CTL_W-1:0];
    end
  end

  // write response; writing the result address answers slverr
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= FEE_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_reg == FEE_ADDR_CONTROL) ? FEE_RESP_OKAY : FEE_RESP_SLVERR;  // see R17
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // axi4-lite read path
  // ------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= FEE_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= FEE_RESP_OKAY;
      case (s_axi_araddr)
        FEE_ADDR_RESULT:  s_axi_rdata <= {24'h00_0000, result_reg};  // see R7 see R8
        FEE_ADDR_CONTROL: s_axi_rdata <= {28'h000_0000, ctl_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= FEE_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_off_holds_clear;
    @(posedge clock) disable iff (!nrst)
      (ctl_reg[1:0] != FEE_MODE_RUN) |=> (period_reg == 8'h00 && tally == '0);
  endproperty
  a_off_holds_clear: assert property (p_off_holds_clear) else $error("counters not cleared while off"); // see R18

  property p_no_trigger_off;
    @(posedge clock) disable iff (!nrst)
      !running |-> !window_trigger;
  endproperty
  a_no_trigger_off: assert property (p_no_trigger_off) else $error("trigger while off"); // see R1

  property p_capture;
    @(posedge clock) disable iff (!nrst)
      trigger |=> (result_reg == $past(tally) && tally == '0);
  endproperty
  a_capture: assert property (p_capture) else $error("result not captured on trigger"); // see R6

  property p_result_stable;
    @(posedge clock) disable iff (!nrst)
      !trigger |=> $stable(result_reg);
  endproperty
  a_result_stable: assert property (p_result_stable) else $error("result changed without trigger"); // see R8

  property p_inc;
    @(posedge clock) disable iff (!nrst)
      (running && !trigger && raise_pulse && !lower_pulse) |=> tally == $past(tally) + 8'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("tally did not wrap-increment"); // see R9

  property p_dec;
    @(posedge clock) disable iff (!nrst)
      (running && !trigger && lower_pulse && !raise_pulse) |=> tally == $past(tally) - 8'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("tally did not decrement"); // see R4

  property p_window;
    @(posedge clock) disable iff (!nrst)
      trigger |-> period_reg == window_len - 8'h01;
  endproperty
  a_window: assert property (p_window) else $error("trigger at wrong count"); // see R3

  property p_ro;
    @(posedge clock) disable iff (!nrst)
      (do_write && awaddr_reg == FEE_ADDR_RESULT) |=> s_axi_bresp == FEE_RESP_SLVERR;
  endproperty
  a_ro: assert property (p_ro) else $error("result write not refused"); // see R17

  property p_rd_result;
    @(posedge clock) disable iff (!nrst)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == FEE_ADDR_RESULT && !trigger)
        |=> s_axi_rdata[7:0] == result_reg;
  endproperty
  a_rd_result: assert property (p_rd_result) else $error("result read mismatch"); // see R7

  c_trigger: cover property (@(posedge clock) disable iff (!nrst) trigger);
  c_wrap:    cover property (@(posedge clock) disable iff (!nrst) tally == 8'h7f ##1 tally == 8'h80);
  c_write:   cover property (@(posedge clock) disable iff (!nrst) do_write);
  c_read:    cover property (@(posedge clock) disable iff (!nrst) s_axi_rvalid && s_axi_rready);
endmodule
`default_nettype wire

// >>> test/fee_top_bench.sv
// self-checking bench for the frequency error estimator top level
`timescale 1ns/1ps
`default_nettype none
module fee_top_bench;
  import fee_pkg::*;
  // ----------------------------------------
  // signals and design instance
  // ----------------------------------------
  logic        clock, nrst, bit_period, raise_pulse, lower_pulse, window_trigger;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          n_fail, total_checks;
  fee_top DUT (.clock(clock), .nrst(nrst), .bit_period(bit_period), .raise_pulse(raise_pulse),
    .lower_pulse(lower_pulse), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .window_trigger(window_trigger));
  // free-running 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // handshakes are judged on values seen at the negedge, which the next posedge then takes
  // no cycle budget per transfer: only the watchdog ends a wait that never gets its answer
  task automatic axi_write(logic [7:0] a, logic [31:0] d, logic [3:0] s, logic [1:0] exp_resp);
    logic aw_ok, w_ok, ra, rw, b;
    logic [1:0] r;
    aw_ok = 0; w_ok = 0; b = 0; r = 2'b11;
    @(posedge clock);
    s_axi_awvalid <= 1; s_axi_awaddr <= a; s_axi_wvalid <= 1; s_axi_wdata <= d; s_axi_wstrb <= s;
    s_axi_bready <= 1;
    while (!(aw_ok && w_ok)) begin
      @(negedge clock); ra = s_axi_awready; rw = s_axi_wready;
      @(posedge clock);
      if (ra === 1'b1 && !aw_ok) begin s_axi_awvalid <= 0; aw_ok = 1; end
      if (rw === 1'b1 && !w_ok) begin s_axi_wvalid <= 0; w_ok = 1; end
    end
    while (!b) begin
      @(negedge clock); b = (s_axi_bvalid === 1'b1); r = s_axi_bresp;
      @(posedge clock);
    end
    s_axi_bready <= 0;
    chk("bresp", {30'b0, exp_resp}, {30'b0, r});
    @(negedge clock); chk("bvalid released", 0, {31'b0, s_axi_bvalid});
  endtask
  task automatic axi_read(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ra, v;
    ra = 0; v = 0;
    @(posedge clock);
    s_axi_arvalid <= 1; s_axi_araddr <= a; s_axi_rready <= 1;
    while (!ra) begin
      @(negedge clock); ra = (s_axi_arready === 1'b1);
      @(posedge clock);
    end
    s_axi_arvalid <= 0;
    while (!v) begin
      @(negedge clock); v = (s_axi_rvalid === 1'b1); d = s_axi_rdata; r = s_axi_rresp;
      @(posedge clock);
    end
    s_axi_rready <= 0;
    @(negedge clock); chk("rvalid released", 0, {31'b0, s_axi_rvalid});
  endtask
  task automatic rd_chk(logic [7:0] a, logic [31:0] exp, logic [1:0] exp_resp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    chk("rdata", exp, d);
    chk("rresp", {30'b0, exp_resp}, {30'b0, r});
  endtask
  // raise pulses then lower pulses, one per cycle, kept clear of bit periods
  task automatic pulses(int up, int dn);
    for (int i = 0; i < up; i++) begin @(posedge clock); raise_pulse <= 1; end
    @(posedge clock); raise_pulse <= 0;
    for (int i = 0; i < dn; i++) begin @(posedge clock); lower_pulse <= 1; end
    @(posedge clock); lower_pulse <= 0;
  endtask
  // back-to-back bit periods; the trigger is expected only at index trig_at
  task automatic bits(int n, int trig_at);
    for (int i = 0; i < n; i++) begin
      @(posedge clock); bit_period <= 1;
      @(negedge clock); chk("window_trigger", {31'b0, i == trig_at}, {31'b0, window_trigger});
    end
    @(posedge clock); bit_period <= 0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd_chk(FEE_ADDR_RESULT, {24'b0, FEE_RESULT_RESET}, FEE_RESP_OKAY);
    rd_chk(FEE_ADDR_CONTROL, {28'b0, FEE_CTL_RESET}, FEE_RESP_OKAY);
  endtask
  // every window code, with a different net tally each time
  task automatic t_windows;
    logic [7:0] win [4];
    win = '{FEE_WIN_0, FEE_WIN_1, FEE_WIN_2, FEE_WIN_3};
    for (int c = 0; c < 4; c++) begin
      axi_write(FEE_ADDR_CONTROL, {28'b0, c[1:0], FEE_MODE_RUN}, 4'hf, FEE_RESP_OKAY);
      rd_chk(FEE_ADDR_CONTROL, {28'b0, c[1:0], FEE_MODE_RUN}, FEE_RESP_OKAY);
      pulses(5 + c, 2);
      bits(win[c], win[c] - 1);
      rd_chk(FEE_ADDR_RESULT, 3 + c, FEE_RESP_OKAY);
    end
  endtask
  // one count past +127 must wrap, and later pulses stay out of the result
  task automatic t_wrap;
    axi_write(FEE_ADDR_CONTROL, {28'b0, FEE_MODE_RUN}, 4'hf, FEE_RESP_OKAY);
    pulses(128, 0);
    bits(8, 7);
    rd_chk(FEE_ADDR_RESULT, 32'h0000_0080, FEE_RESP_OKAY);
    pulses(4, 1);
    rd_chk(FEE_ADDR_RESULT, 32'h0000_0080, FEE_RESP_OKAY);
    pulses(0, 3);
    bits(8, 7);
    rd_chk(FEE_ADDR_RESULT, 32'h0000_0000, FEE_RESP_OKAY);
  endtask
  // turning off in mid-window must throw away both counts
  task automatic t_off;
    pulses(3, 0);
    bits(5, -1);
    axi_write(FEE_ADDR_CONTROL, {28'b0, FEE_MODE_OFF}, 4'hf, FEE_RESP_OKAY);
    pulses(2, 0);
    bits(9, -1);
    axi_write(FEE_ADDR_CONTROL, {28'b0, FEE_MODE_RUN}, 4'hf, FEE_RESP_OKAY);
    pulses(1, 0);
    bits(8, 7);
    rd_chk(FEE_ADDR_RESULT, 1, FEE_RESP_OKAY);
  endtask
  // result is read only; unmapped reads and strobe-less writes change nothing
  task automatic t_bus;
    axi_write(FEE_ADDR_RESULT, 32'h0000_0055, 4'hf, FEE_RESP_SLVERR);
    rd_chk(FEE_ADDR_RESULT, 1, FEE_RESP_OKAY);
    rd_chk(8'h40, 32'h0000_0000, FEE_RESP_SLVERR);
    axi_write(FEE_ADDR_CONTROL, 32'h0000_000c, 4'h0, FEE_RESP_OKAY);
    rd_chk(FEE_ADDR_CONTROL, {28'b0, FEE_MODE_RUN}, FEE_RESP_OKAY);
  endtask
  // host-side trim search on the sign alone; the modelled crystal sits off by (trim - 21) counts
  task automatic t_trim;
    logic [31:0] d;
    logic [1:0]  r;
    int          present, step, off;
    logic        pos;
    present = 16; step = 16; pos = 0;
    axi_write(FEE_ADDR_CONTROL, {28'b0, 2'b00, FEE_MODE_RUN}, 4'hf, FEE_RESP_OKAY);
    while (step > 1) begin
      step = step / 2;
      present = pos ? present - step : present + step;
      off = present - 21;
      pulses(4 + (off > 0 ? off : 0), 4 + (off < 0 ? -off : 0));
      bits(8, 7);
      axi_read(FEE_ADDR_RESULT, d, r);
      chk("trim result", {24'b0, off[7:0]}, d);
      pos = ($signed(d[7:0]) > 0);
    end
    if (pos) present = present - 1;
    chk("trim value", 21, present);
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // the whole sequence needs well under 3000 cycles; the limit leaves ample margin
  initial begin
    #200000;
    n_fail++;
    $display("[FAIL] watchdog expected done seen timeout");
    give_verdict();
  end
  initial begin
    n_fail = 0; total_checks = 0;
    nrst <= 0; bit_period <= 0; raise_pulse <= 0; lower_pulse <= 0;
    s_axi_awvalid <= 0; s_axi_awaddr <= 0; s_axi_wvalid <= 0; s_axi_wdata <= 0; s_axi_wstrb <= 0;
    s_axi_bready <= 0; s_axi_arvalid <= 0; s_axi_araddr <= 0; s_axi_rready <= 0;
    repeat (20) @(posedge clock);
    nrst <= 1;
    t_reset();
    t_windows();
    t_wrap();
    t_off();
    t_bus();
    t_trim();
    give_verdict();
  end
endmodule
`default_nettype wire
